/* bench/fcs_sequencer_props.sv */
`timescale 1ns/1ps
module fcs_sequencer_props
  import fcs_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        mode_allows_cmd,
  input wire logic        erase_strobe,
  input wire logic [11:0] erase_addr,
  input wire logic [1:0]  pf_margin,
  input wire logic [1:0]  df_margin,
  input wire logic        busy
);
  logic        wr_stat_q;
  logic        next_wr_stat;
  logic [12:0] strb_cnt_q;
  logic [12:0] next_strb_cnt;
  logic        launch_try;

  // strobes are counted per command so the total can be judged when busy drops
  always_comb
  begin
    next_wr_stat  = hsel && hready && htrans[1] && hwrite && (haddr[7:0] == 8'h00);
    next_strb_cnt = busy ? strb_cnt_q + {12'h0, erase_strobe} : 13'h0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_stat_q  <= 1'b0;
      strb_cnt_q <= 13'h0;
    end
    else
    begin
      wr_stat_q  <= next_wr_stat;
      strb_cnt_q <= next_strb_cnt;
    end
  end

  assign launch_try = wr_stat_q && hwdata[7];

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_strobe_busy;
    erase_strobe |-> busy;
  endproperty
  a_strobe_busy: assert property (p_strobe_busy)
    else $error("erase strobe outside a running command");
  property p_addr_step;
    erase_strobe && $past(erase_strobe) |-> erase_addr == $past(erase_addr) + 12'h1;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("erase address skipped");
  property p_mode_refuse;
    launch_try && !busy && !mode_allows_cmd |=> !busy;
  endproperty
  a_mode_refuse: assert property (p_mode_refuse)
    else $error("command ran in a mode that forbids it");
  property p_busy_cause;
    $rose(busy) |-> $past(launch_try);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without a launch");
  property p_strobe_count;
    $fell(busy) && strb_cnt_q != 13'h0 |-> strb_cnt_q == 13'h1000 || strb_cnt_q == 13'h20;
  endproperty
  a_strobe_count: assert property (p_strobe_count)
    else $error("wrong number of erased addresses");
  property p_verify_after;
    $fell(erase_strobe) |-> busy [*8];
  endproperty
  a_verify_after: assert property (p_verify_after)
    else $error("no verify pass after erase");
  property p_margin_cause;
    $changed(pf_margin) || $changed(df_margin) |-> $past(launch_try);
  endproperty
  a_margin_cause: assert property (p_margin_cause)
    else $error("margin changed without a launch");
  property p_margin_both;
    $changed(pf_margin) |-> df_margin == pf_margin;
  endproperty
  a_margin_both: assert property (p_margin_both)
    else $error("program margin not applied to data reads");
  property p_margin_code;
    pf_margin != 2'h3 && df_margin != 2'h3;
  endproperty
  a_margin_code: assert property (p_margin_code)
    else $error("margin level out of range");

  c_blk: cover property ($fell(busy) && strb_cnt_q == 13'h1000);
  c_sec: cover property ($fell(busy) && strb_cnt_q == 13'h20);
  c_mrg: cover property ($changed(df_margin));
endmodule : fcs_sequencer_props

bind fcs_sequencer fcs_sequencer_props props_u
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .mode_allows_cmd, .erase_strobe, .erase_addr, .pf_margin, .df_margin, .busy
);

/* bench/fcs_sequencer_tb.sv */
`timescale 1ns/1ps
module fcs_sequencer_tb;
  import fcs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, mode_allows_cmd;
  logic        pf_protected, df_protected, verify_fail, verify_fatal, erase_strobe, busy;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, key_access_enable, pf_margin, df_margin;
  logic [2:0]  hsize;
  logic [11:0] erase_addr;
  int          n_fail, n_checks, n_strb, cyc;

  fcs_sequencer dut_u
  (
    .hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mode_allows_cmd,
    .pf_protected, .df_protected, .key_access_enable, .verify_fail, .verify_fatal,
    .erase_strobe, .erase_addr, .pf_margin, .df_margin, .busy
  );

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // a hang is cut short here, well past the longest erase
  always @(posedge hclk)
  begin
    cyc++;
    if (erase_strobe === 1'b1)
      n_strb++;
    if (cyc == 30000)
    begin
      n_fail++;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic put(input logic [2:0] i, input logic [15:0] v);
    xfer(8'h04, 1'b1, {29'h0, i});
    xfer(8'h08, 1'b1, {16'h0, v});
  endtask : put

  // stale error flags are cleared first so each launch is judged alone
  task automatic go(input logic [31:0] st);
    xfer(8'h00, 1'b1, 32'h30);
    n_strb = 0;
    xfer(8'h00, 1'b1, 32'h80);
    repeat (5000)
    begin
      xfer(8'h00, 1'b0, 32'h0);
      if (q[7] === 1'b1)
        break;
    end
    chk(q, st);
    $display("test done t=%0t", $time);
  endtask : go

  task automatic ers(input logic [15:0] w0, input logic [15:0] w1, input logic [2:0] ix,
                     input logic m, input logic [1:0] pr, input logic [31:0] st, input int ns);
    mode_allows_cmd <= m;
    {pf_protected, df_protected} <= pr;
    put(3'h0, w0);
    put(3'h1, w1);
    xfer(8'h04, 1'b1, {29'h0, ix});
    go(st);
    chk(n_strb, ns);
  endtask : ers

  task automatic key(input logic [15:0] w4, input logic [2:0] ix, input logic [1:0] en,
                     input logic [31:0] st);
    key_access_enable <= en;
    put(3'h0, 16'h0c00);
    put(3'h1, 16'h0123);
    put(3'h2, 16'h4567);
    put(3'h3, 16'h89ab);
    put(3'h4, w4);
    xfer(8'h04, 1'b1, {29'h0, ix});
    go(st);
  endtask : key

  task automatic mrg(input logic [1:0] blk, input logic [15:0] c);
    put(3'h0, {8'h0d, 6'h0, blk});
    put(3'h1, c);
    go(32'h80);
  endtask : mrg

  initial
  begin
    {hsel, hwrite, mode_allows_cmd, pf_protected, df_protected} = 5'b10100;
    {verify_fail, verify_fatal, hresetn} = 3'b000;
    {haddr, hwdata, q} = '0;
    {htrans, hsize, key_access_enable} = 7'b00_010_10;
    {n_fail, n_checks, n_strb, cyc} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(8'h00, 1'b0, 32'h0);
    chk(q, 32'h80);
    chk({31'h0, hresp}, 32'h0);
    ers(16'h0900, 16'h0000, 3'h0, 1'b1, 2'b00, 32'ha0, 0);
    ers(16'h0900, 16'h0000, 3'h1, 1'b0, 2'b00, 32'ha0, 0);
    ers(16'h0902, 16'h0000, 3'h1, 1'b1, 2'b00, 32'ha0, 0);
    ers(16'h0900, 16'h0004, 3'h1, 1'b1, 2'b00, 32'ha0, 0);
    ers(16'h0901, 16'h0001, 3'h1, 1'b1, 2'b00, 32'ha0, 0);
    ers(16'h0900, 16'h0000, 3'h1, 1'b1, 2'b10, 32'h90, 0);
    ers(16'h0901, 16'h0000, 3'h1, 1'b1, 2'b01, 32'h90, 0);
    ers(16'h0800, 16'h0000, 3'h1, 1'b1, 2'b00, 32'ha0, 0);
    ers(16'h0800, 16'h0000, 3'h0, 1'b1, 2'b10, 32'h90, 0);
    ers(16'h0800, 16'h0000, 3'h0, 1'b1, 2'b01, 32'h90, 0);
    {pf_protected, df_protected} <= 2'b00;
    xfer(8'h14, 1'b1, 32'h89abcdef);
    xfer(8'h18, 1'b1, 32'h01234567);
    key(16'hcdef, 3'h4, 2'h1, 32'ha0);
    key(16'hcdef, 3'h3, 2'h2, 32'ha0);
    key(16'hcdef, 3'h4, 2'h2, 32'h80);
    key(16'hcdee, 3'h4, 2'h2, 32'ha0);
    key(16'hcdef, 3'h4, 2'h2, 32'ha0);
    for (int c = 0; c < 3; c++)
    begin
      mrg(2'h1, c[15:0]);
      chk({28'h0, df_margin, pf_margin}, {28'h0, c[1:0], 2'h0});
    end
    for (int c = 0; c < 3; c++)
    begin
      mrg(2'h0, c[15:0]);
      chk({28'h0, df_margin, pf_margin}, {28'h0, c[1:0], c[1:0]});
    end
    mrg(2'h1, 16'h0001);
    chk({28'h0, df_margin, pf_margin}, 32'h6);
    put(3'h1, 16'h0003);
    go(32'ha0);
    chk({28'h0, df_margin, pf_margin}, 32'h6);
    {verify_fail, verify_fatal} <= 2'b11;
    ers(16'h0a00, 16'h0000, 3'h1, 1'b1, 2'b00, 32'h83, 32);
    chk({20'h0, erase_addr}, 32'h1f);
    verify_fatal <= 1'b0;
    ers(16'h0900, 16'h0000, 3'h1, 1'b1, 2'b00, 32'h82, 4096);
    chk({20'h0, erase_addr}, 32'hfff);
    complete_run;
  end
endmodule : fcs_sequencer_tb

/* rtl/fcs_pkg.sv */
package fcs_pkg;
  typedef enum logic [3:0]
  {
    fcs_idle    = 4'b0001,
    fcs_erase   = 4'b0010,
    fcs_verify  = 4'b0100,
    fcs_done    = 4'b1000
  } fcs_state_type;
endpackage : fcs_pkg

/* rtl/fcs_regs.svh */
// Operation
// - erase block erases, verifies, sets complete flag
// - erase block with index not 001 errors
// - command not allowed in mode errors
// - invalid block select errors on erase block
// - misaligned erase block address errors
// - protected block region flags protection violation
// - verify sets error and uncorrectable flags
// - erase all with index not 000 errors
// - any protection flags violation on erase all
// - erase sector clears whole program sector
// - key verify with index not 100 errors
// - wrong backdoor key sets access error
// - key verify needs key enable 10
// - second key attempt after mismatch errors
// - margin command applies level then completes
// - data block margin affects data reads only
// - program block margin affects both reads
// - margin codes: 0 normal, 1 erased, 2 programmed
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH
`define FCS_OFS_STAT     4'h0
`define FCS_OFS_INDEX    4'h1
`define FCS_OFS_PARAM    4'h2
`define FCS_OFS_CTRL     4'h3
`define FCS_OFS_MARGIN   4'h4
`define FCS_OFS_KEY_LO   4'h5
`define FCS_OFS_KEY_HI   4'h6
`define FCS_BIT_CCF      7
`define FCS_BIT_ACC      5
`define FCS_BIT_PROT     4
`define FCS_BIT_VERR     1
`define FCS_BIT_VUNC     0
`define FCS_CMD_ERS_ALL  8'h08
`define FCS_CMD_ERS_BLK  8'h09
`define FCS_CMD_ERS_SEC  8'h0a
`define FCS_CMD_KEY      8'h0c
`define FCS_CMD_MARGIN   8'h0d
`define FCS_IDX_0        3'h0
`define FCS_IDX_1        3'h1
`define FCS_IDX_4        3'h4
`define FCS_BLK_PF       2'h0
`define FCS_BLK_DF       2'h1
`define FCS_KEY_ON       2'h2
`define FCS_MRG_NORMAL   16'h0000
`define FCS_MRG_ERASED   16'h0001
`define FCS_MRG_PROG     16'h0002
`define FCS_BLK_LEN      12'hfff
`define FCS_SEC_LEN      12'h01f
`define FCS_ALL_LEN      12'hfff
`endif

/* rtl/fcs_sequencer.sv */
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "fcs_regs.svh"
module fcs_sequencer
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        mode_allows_cmd,
  input  wire logic        pf_protected,
  input  wire logic        df_protected,
  input  wire logic [1:0]  key_access_enable,
  input  wire logic        verify_fail,
  input  wire logic        verify_fatal,
  output logic             erase_strobe,
  output logic      [11:0] erase_addr,
  output logic      [1:0]  pf_margin,
  output logic      [1:0]  df_margin,
  output logic             busy
);
  import fcs_pkg::*;

  fcs_state_type state;
  fcs_state_type next_state;
  logic [15:0] command_parameter_words [0:7];
  logic [2:0]  parameter_word_index;
  logic        command_complete_flag;
  logic        access_error_flag;
  logic        protection_violation_flag;
  logic        verify_error_flag;
  logic        verify_uncorrectable_flag;
  logic        key_mismatch_seen;
  logic [63:0] stored_key;
  logic [11:0] count;
  logic [11:0] limit;
  logic        ap_valid;
  logic        ap_write;
  logic [3:0]  ap_reg;
  logic        rsp_ready;
  logic        rsp_err;
  logic [31:0] rd_data;

  logic [11:0] next_count;
  logic [11:0] next_limit;
  logic        next_ccf;
  logic        next_acc;
  logic        next_prot;
  logic        next_verr;
  logic        next_vunc;
  logic        next_mismatch;
  logic        next_erase_strobe;
  logic [11:0] next_erase_addr;
  logic [1:0]  next_pf_margin;
  logic [1:0]  next_df_margin;
  logic [31:0] next_rd_data;

  logic        wr_stat;
  logic        launch;
  logic [7:0]  cmd_code;
  logic [1:0]  blk_sel;
  logic        launch_err;
  logic        launch_prot;
  logic [63:0] key_in;

  assign wr_stat = ap_valid && ap_write && (ap_reg == `FCS_OFS_STAT);
  assign launch  = wr_stat && hwdata[`FCS_BIT_CCF] && command_complete_flag
                   && (state == fcs_idle);
  assign cmd_code = command_parameter_words[0][15:8];
  assign blk_sel  = command_parameter_words[0][1:0];
  assign key_in   = {command_parameter_words[1], command_parameter_words[2],
                     command_parameter_words[3], command_parameter_words[4]};

  // launch checks, evaluated once at the clearing write
  always_comb
  begin
    launch_err  = 1'b0;
    launch_prot = 1'b0;
    if (!mode_allows_cmd)
      launch_err = 1'b1;
    unique case (cmd_code)
      `FCS_CMD_ERS_BLK:
      begin
        if (parameter_word_index != `FCS_IDX_1)
          launch_err = 1'b1;
        if (blk_sel != `FCS_BLK_PF && blk_sel != `FCS_BLK_DF)
          launch_err = 1'b1;
        if (blk_sel == `FCS_BLK_PF && command_parameter_words[1][2:0] != 3'h0)
          launch_err = 1'b1;
        if (blk_sel == `FCS_BLK_DF && command_parameter_words[1][0])
          launch_err = 1'b1;
        if ((blk_sel == `FCS_BLK_PF && pf_protected) ||
            (blk_sel == `FCS_BLK_DF && df_protected))
          launch_prot = 1'b1;
      end
      `FCS_CMD_ERS_ALL:
      begin
        if (parameter_word_index != `FCS_IDX_0)
          launch_err = 1'b1;
        if (pf_protected || df_protected)
          launch_prot = 1'b1;
      end
      `FCS_CMD_ERS_SEC:
      begin
        if (parameter_word_index != `FCS_IDX_1)
          launch_err = 1'b1;
        if (pf_protected)
          launch_prot = 1'b1;
      end
      `FCS_CMD_KEY:
      begin
        if (parameter_word_index != `FCS_IDX_4)
          launch_err = 1'b1;
        if (key_access_enable != `FCS_KEY_ON)
          launch_err = 1'b1;
        if (key_mismatch_seen)
          launch_err = 1'b1;
        if (key_in != stored_key)
          launch_err = 1'b1;
      end
      `FCS_CMD_MARGIN:
      begin
        if (parameter_word_index != `FCS_IDX_1 ||
            (blk_sel != `FCS_BLK_PF && blk_sel != `FCS_BLK_DF) ||
            command_parameter_words[1] > `FCS_MRG_PROG)
          launch_err = 1'b1;
      end
      default:
        launch_err = 1'b1;
    endcase
  end

  // sequencer; verify status is sampled over the whole verify pass
  always_comb
  begin
    next_state        = state;
    next_count        = count;
    next_limit        = limit;
    next_ccf          = command_complete_flag;
    next_acc          = access_error_flag;
    next_prot         = protection_violation_flag;
    next_verr         = verify_error_flag;
    next_vunc         = verify_uncorrectable_flag;
    next_mismatch     = key_mismatch_seen;
    next_erase_strobe = 1'b0;
    next_erase_addr   = erase_addr;
    next_pf_margin    = pf_margin;
    next_df_margin    = df_margin;
    if (wr_stat && hwdata[`FCS_BIT_ACC])
      next_acc = 1'b0;
    if (wr_stat && hwdata[`FCS_BIT_PROT])
      next_prot = 1'b0;
    unique case (state)
      fcs_idle:
      begin
        if (launch)
        begin
          next_verr = 1'b0;
          next_vunc = 1'b0;
          if (cmd_code == `FCS_CMD_KEY && key_in != stored_key)
            next_mismatch = 1'b1;
          if (launch_err || launch_prot)
          begin
            next_acc = next_acc | launch_err;
            next_prot = next_prot | launch_prot;
            next_ccf = 1'b1;
          end
          else
          begin
            next_ccf = 1'b0;
            next_count = 12'h000;
            unique case (cmd_code)
              `FCS_CMD_ERS_BLK:
              begin
                next_limit = `FCS_BLK_LEN;
                next_state = fcs_erase;
              end
              `FCS_CMD_ERS_SEC:
              begin
                next_limit = `FCS_SEC_LEN;
                next_state = fcs_erase;
              end
              `FCS_CMD_ERS_ALL:
              begin
                next_limit = `FCS_ALL_LEN;
                next_state = fcs_erase;
              end
              `FCS_CMD_MARGIN:
              begin
                if (blk_sel == `FCS_BLK_PF)
                begin
                  next_pf_margin = command_parameter_words[1][1:0];
                  next_df_margin = command_parameter_words[1][1:0];
                end
                else
                  next_df_margin = command_parameter_words[1][1:0];
                next_state = fcs_done;
              end
              default:
                next_state = fcs_done;
            endcase
          end
        end
      end
      fcs_erase:
      begin
        next_erase_strobe = 1'b1;
        next_erase_addr   = count;
        next_count        = count + 12'h001;
        if (count == limit)
        begin
          next_count = 12'h000;
          next_state = fcs_verify;
        end
      end
      fcs_verify:
      begin
        next_count = count + 12'h001;
        if (verify_fail)
          next_verr = 1'b1;
        if (verify_fatal)
          next_vunc = 1'b1;
        if (count == limit)
          next_state = fcs_done;
      end
      fcs_done:
      begin
        next_ccf   = 1'b1;
        next_state = fcs_idle;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state                     <= fcs_idle;
      count                     <= 12'h000;
      limit                     <= 12'h000;
      command_complete_flag     <= 1'b1;
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      verify_error_flag         <= 1'b0;
      verify_uncorrectable_flag <= 1'b0;
      key_mismatch_seen         <= 1'b0;
      erase_strobe              <= 1'b0;
      erase_addr                <= 12'h000;
      pf_margin                 <= 2'h0;
      df_margin                 <= 2'h0;
      busy                      <= 1'b0;
    end
    else if (clk_en)
    begin
      state                     <= next_state;
      count                     <= next_count;
      limit                     <= next_limit;
      command_complete_flag     <= next_ccf;
      access_error_flag         <= next_acc;
      protection_violation_flag <= next_prot;
      verify_error_flag         <= next_verr;
      verify_uncorrectable_flag <= next_vunc;
      key_mismatch_seen         <= next_mismatch;
      erase_strobe              <= next_erase_strobe;
      erase_addr                <= next_erase_addr;
      pf_margin                 <= next_pf_margin;
      df_margin                 <= next_df_margin;
      busy                      <= (next_state != fcs_idle);
    end
  end

  // bus slave: zero wait states, writes land in the data phase
  always_comb
  begin
    next_rd_data = 32'h0000_0000;
    unique case (haddr[5:2])
      `FCS_OFS_STAT:
        next_rd_data = {24'h00_0000, command_complete_flag, 1'b0, access_error_flag,
                        protection_violation_flag, 2'b00, verify_error_flag,
                        verify_uncorrectable_flag};
      `FCS_OFS_INDEX:
        next_rd_data = {29'h0000_0000, parameter_word_index};
      `FCS_OFS_PARAM:
        next_rd_data = {16'h0000, command_parameter_words[parameter_word_index]};
      `FCS_OFS_CTRL:
        next_rd_data = {31'h0000_0000, busy};
      `FCS_OFS_MARGIN:
        next_rd_data = {28'h000_0000, df_margin, pf_margin};
      default:
        next_rd_data = 32'h0000_0000;
    endcase
  end

  // parameters and index are locked while a command runs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid             <= 1'b0;
      ap_write             <= 1'b0;
      ap_reg               <= 4'h0;
      rsp_ready            <= 1'b1;
      rsp_err              <= 1'b0;
      rd_data              <= 32'h0000_0000;
      parameter_word_index <= 3'h0;
      stored_key           <= 64'h0000_0000_0000_0000;
      for (int i = 0; i < 8; i++)
        command_parameter_words[i] <= 16'h0000;
    end
    else if (clk_en)
    begin
      ap_valid  <= hsel && hready && htrans[1];
      ap_write  <= hwrite;
      ap_reg    <= haddr[5:2];
      rsp_ready <= 1'b1;
      // errors go to the status flags, so the bus response stays okay
      rsp_err   <= 1'b0;
      if (hsel && hready && htrans[1] && !hwrite)
        rd_data <= next_rd_data;
      if (ap_valid && ap_write && command_complete_flag)
      begin
        if (ap_reg == `FCS_OFS_INDEX)
          parameter_word_index <= hwdata[2:0];
        if (ap_reg == `FCS_OFS_PARAM)
          command_parameter_words[parameter_word_index] <= hwdata[15:0];
        if (ap_reg == `FCS_OFS_KEY_LO)
          stored_key[31:0] <= hwdata;
        if (ap_reg == `FCS_OFS_KEY_HI)
          stored_key[63:32] <= hwdata;
      end
    end
  end

  assign hrdata    = rd_data;
  assign hreadyout = rsp_ready;
  assign hresp     = rsp_err;
endmodule : fcs_sequencer
